/* rtl/rcpc_defs.vh */
// Constants for the reclocker output path control block
`ifndef RCPC_DEFS_VH
`define RCPC_DEFS_VH

// Register byte offsets
`define RCPC_OFF_CTRL 12'h000
`define RCPC_OFF_STATUS 12'h004
`define RCPC_OFF_INT_STATUS 12'h008
`define RCPC_OFF_INT_MASK 12'h00C

// Control register fields
`define RCPC_CTRL_SW_OVR 0
`define RCPC_CTRL_UNLOCK_PT 1
`define RCPC_CTRL_FORCED_PT 2
`define RCPC_CTRL_SILENCE_N 3
`define RCPC_CTRL_BW_BOOST_N 4
`define RCPC_CTRL_SEL_LO 5
`define RCPC_CTRL_SEL_HI 6
`define RCPC_CTRL_W 7
// Pull defaults: passthrough on, forced off, not silenced, low bandwidth, input 0
`define RCPC_CTRL_RST 7'h1A

// Status register fields
`define RCPC_ST_LOCKED 0
`define RCPC_ST_SD 1
`define RCPC_ST_BYPASS 2
`define RCPC_ST_MUTED 3
`define RCPC_ST_RATE_LO 4
`define RCPC_ST_RATE_HI 6

// Interrupt fields
`define RCPC_INT_LOCK_GAIN 0
`define RCPC_INT_LOCK_LOSS 1
`define RCPC_INT_RATE_CHG 2
`define RCPC_INT_W 3
`define RCPC_INT_MASK_RST 3'h0

// Rate code of the high-definition range
`define RCPC_RATE_HD 3'h5

// Synchroniser reset values: pins at pull defaults, lanes idle
`define RCPC_PIN_SYNC_RST 9'h068
`define RCPC_FREQ_SYNC_RST 15'h7FFF
`define RCPC_LANE_P_RST 4'h0
`define RCPC_LANE_N_RST 4'hF
`define RCPC_RT_RST 2'h1

// Frequency tolerances in ppm
`define RCPC_LOCK_PPM 12'd2000
`define RCPC_UNLOCK_PPM 12'd3000

`endif

/* rtl/rcpc_sync.v */
// Two-stage synchroniser, one chain per bit
`timescale 1ns/1ps
module rcpc_sync #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg s1_q;
            reg s2_q;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_q <= RST[i];
                    s2_q <= RST[i];
                end
                else
                begin
                    s1_q <= d[i];
                    s2_q <= s1_q;
                end
            end
            assign q[i] = s2_q;
        end
    endgenerate
endmodule // rcpc_sync

/* rtl/rcpc_lock_fsm.v */
// Lock acquisition state machine with hysteresis
`timescale 1ns/1ps
`include "rcpc_defs.vh"
module rcpc_lock_fsm (
    input wire pclk,
    input wire presetn,
    input wire signal_present,
    input wire [11:0] freq_err_ppm,
    output wire locked,
    output wire fll_enable
);
    localparam ST_ACQ = 1'b0;
    localparam ST_LOCK = 1'b1;
    reg state_q;
    reg state_d;

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_ACQ:
            begin
                if (signal_present && freq_err_ppm <= `RCPC_LOCK_PPM)
                    state_d = ST_LOCK;
            end
            ST_LOCK:
            begin
                if (!signal_present || freq_err_ppm > `RCPC_UNLOCK_PPM)
                    state_d = ST_ACQ;
            end
            default:
                state_d = ST_ACQ;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_ACQ;
        else
            state_q <= state_d;
    end

    assign locked = state_q;
    assign fll_enable = ~state_q;
endmodule // rcpc_lock_fsm

/* rtl/rcpc_top.v */
// Reclocker output path control: lock, rate flag, output source and bandwidth
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rcpc_defs.vh"
module rcpc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire pins_connected,
    input wire unlock_passthrough_en,
    input wire forced_passthrough,
    input wire output_silence_n,
    input wire loop_bw_boost_n,
    input wire [1:0] input_choice,
    input wire signal_present,
    input wire [11:0] freq_err_ppm,
    input wire [2:0] locked_rate,
    input wire [3:0] serial_in_p,
    input wire [3:0] serial_in_n,
    input wire retimed_p,
    input wire retimed_n,
    output reg retime_feed_p,
    output reg retime_feed_n,
    output reg serial_out_p,
    output reg serial_out_n,
    output reg lock_indicator_n,
    output reg sd_rate_flag,
    output reg loop_bw_high,
    output reg fll_enable
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    wire pins_conn_s;
    wire unlock_pt_s;
    wire forced_pt_s;
    wire silence_n_s;
    wire bw_boost_n_s;
    wire [1:0] choice_s;
    wire sig_present_s;
    wire [11:0] ferr_s;
    wire [2:0] rate_s;
    wire [8:0] ctrl_pins_s;
    wire [3:0] lane_p_s;
    wire [3:0] lane_n_s;
    wire rt_p_s;
    wire rt_n_s;

    rcpc_sync #(.W(9), .RST(`RCPC_PIN_SYNC_RST)) u_sync_ctrl (
        .pclk(pclk),
        .presetn(presetn),
        .d({input_choice, loop_bw_boost_n, output_silence_n, forced_passthrough,
            unlock_passthrough_en, pins_connected, signal_present, 1'b0}),
        .q(ctrl_pins_s)
    );
    assign choice_s = ctrl_pins_s[8:7];
    assign bw_boost_n_s = ctrl_pins_s[6];
    assign silence_n_s = ctrl_pins_s[5];
    assign forced_pt_s = ctrl_pins_s[4];
    assign unlock_pt_s = ctrl_pins_s[3];
    assign pins_conn_s = ctrl_pins_s[2];
    assign sig_present_s = ctrl_pins_s[1];

    // Frequency error is slow-moving; a torn sample can delay lock, or drop lock for a cycle while locked
    rcpc_sync #(.W(15), .RST(`RCPC_FREQ_SYNC_RST)) u_sync_freq (
        .pclk(pclk),
        .presetn(presetn),
        .d({locked_rate, freq_err_ppm}),
        .q({rate_s, ferr_s})
    );

    // Lane data is not timed to pclk; same two stages as the pins
    rcpc_sync #(.W(4), .RST(`RCPC_LANE_P_RST)) u_sync_lane_p (
        .pclk(pclk),
        .presetn(presetn),
        .d(serial_in_p),
        .q(lane_p_s)
    );

    rcpc_sync #(.W(4), .RST(`RCPC_LANE_N_RST)) u_sync_lane_n (
        .pclk(pclk),
        .presetn(presetn),
        .d(serial_in_n),
        .q(lane_n_s)
    );

    rcpc_sync #(.W(2), .RST(`RCPC_RT_RST)) u_sync_rt (
        .pclk(pclk),
        .presetn(presetn),
        .d({retimed_p, retimed_n}),
        .q({rt_p_s, rt_n_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg [`RCPC_CTRL_W-1:0] ctrl_q;
    reg [`RCPC_INT_W-1:0] int_st_q;
    reg [`RCPC_INT_W-1:0] int_st_d;
    reg [`RCPC_INT_W-1:0] int_mask_q;
    reg locked_d1_q;
    reg [2:0] rate_q;
    wire locked;
    wire fll_en;
    wire acc;
    wire wr_en;
    wire [`RCPC_INT_W-1:0] events;
    reg [31:0] rdata_d;
    reg addr_ok;

    rcpc_lock_fsm u_lock (
        .pclk(pclk),
        .presetn(presetn),
        .signal_present(sig_present_s),
        .freq_err_ppm(ferr_s),
        .locked(locked),
        .fll_enable(fll_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Effective control values
    reg eff_unlock_pt;
    reg eff_forced_pt;
    reg eff_silence_n;
    reg eff_bw_boost_n;
    reg [1:0] eff_choice;

    always @*
    begin
        if (ctrl_q[`RCPC_CTRL_SW_OVR] || !pins_conn_s)
        begin
            eff_unlock_pt = ctrl_q[`RCPC_CTRL_UNLOCK_PT];
            eff_forced_pt = ctrl_q[`RCPC_CTRL_FORCED_PT];
            eff_silence_n = ctrl_q[`RCPC_CTRL_SILENCE_N];
            eff_bw_boost_n = ctrl_q[`RCPC_CTRL_BW_BOOST_N];
            eff_choice = ctrl_q[`RCPC_CTRL_SEL_HI:`RCPC_CTRL_SEL_LO];
        end
        else
        begin
            eff_unlock_pt = unlock_pt_s;
            eff_forced_pt = forced_pt_s;
            eff_silence_n = silence_n_s;
            eff_bw_boost_n = bw_boost_n_s;
            eff_choice = choice_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data path selection
    reg sel_p;
    reg sel_n;
    reg bypass;

    always @*
    begin
        case (eff_choice)
            2'h0:
            begin
                sel_p = lane_p_s[0];
                sel_n = lane_n_s[0];
            end
            2'h1:
            begin
                sel_p = lane_p_s[1];
                sel_n = lane_n_s[1];
            end
            2'h2:
            begin
                sel_p = lane_p_s[2];
                sel_n = lane_n_s[2];
            end
            default:
            begin
                sel_p = lane_p_s[3];
                sel_n = lane_n_s[3];
            end
        endcase
        bypass = eff_forced_pt | (eff_unlock_pt & ~locked);
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            retime_feed_p <= 1'b0;
            retime_feed_n <= 1'b1;
            serial_out_p <= 1'b0;
            serial_out_n <= 1'b0;
            loop_bw_high <= 1'b0;
            fll_enable <= 1'b1;
        end
        else
        begin
            retime_feed_p <= sel_p;
            retime_feed_n <= sel_n;
            fll_enable <= fll_en;
            loop_bw_high <= ~eff_bw_boost_n;
            if (!eff_silence_n)
            begin
                serial_out_p <= 1'b0;
                serial_out_n <= 1'b0;
            end
            else if (bypass)
            begin
                serial_out_p <= sel_p;
                serial_out_n <= sel_n;
            end
            else
            begin
                serial_out_p <= rt_p_s;
                serial_out_n <= rt_n_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_indicator_n <= 1'b0;
            sd_rate_flag <= 1'b1;
            locked_d1_q <= 1'b0;
            rate_q <= 3'h0;
        end
        else
        begin
            lock_indicator_n <= locked;
            locked_d1_q <= locked;
            // Flag holds last locked rate while acquiring
            if (locked)
            begin
                rate_q <= rate_s;
                sd_rate_flag <= (rate_s != `RCPC_RATE_HD);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and interrupt
    assign events[`RCPC_INT_LOCK_GAIN] = locked & ~locked_d1_q;
    assign events[`RCPC_INT_LOCK_LOSS] = ~locked & locked_d1_q;
    assign events[`RCPC_INT_RATE_CHG] = locked & locked_d1_q & (rate_s != rate_q);

    assign acc = psel & penable & pready;
    assign wr_en = acc & pwrite & addr_ok;

    always @*
    begin
        // Set wins over a simultaneous write-one clear
        int_st_d = int_st_q;
        if (wr_en && paddr == `RCPC_OFF_INT_STATUS)
            int_st_d = int_st_q & ~pwdata[`RCPC_INT_W-1:0];
        int_st_d = int_st_d | events;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, pready from a flop
    always @*
    begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            `RCPC_OFF_CTRL:
                rdata_d[`RCPC_CTRL_W-1:0] = ctrl_q;
            `RCPC_OFF_STATUS:
            begin
                rdata_d[`RCPC_ST_LOCKED] = locked;
                rdata_d[`RCPC_ST_SD] = sd_rate_flag;
                rdata_d[`RCPC_ST_BYPASS] = bypass;
                rdata_d[`RCPC_ST_MUTED] = ~eff_silence_n;
                rdata_d[`RCPC_ST_RATE_HI:`RCPC_ST_RATE_LO] = rate_q;
            end
            `RCPC_OFF_INT_STATUS:
                rdata_d[`RCPC_INT_W-1:0] = int_st_q;
            `RCPC_OFF_INT_MASK:
                rdata_d[`RCPC_INT_W-1:0] = int_mask_q;
            default:
                addr_ok = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl_q <= `RCPC_CTRL_RST;
            int_st_q <= {`RCPC_INT_W{1'b0}};
            int_mask_q <= `RCPC_INT_MASK_RST;
            irq <= 1'b0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            if (psel && penable && !pready)
                prdata <= pwrite ? 32'h0000_0000 : rdata_d;
            if (wr_en && paddr == `RCPC_OFF_CTRL)
                ctrl_q <= pwdata[`RCPC_CTRL_W-1:0];
            if (wr_en && paddr == `RCPC_OFF_INT_MASK)
                int_mask_q <= pwdata[`RCPC_INT_W-1:0];
            int_st_q <= int_st_d;
            irq <= |(int_st_d & int_mask_q);
        end
    end
endmodule // rcpc_top

/* verif/rcpc_far_model.sv */
// Far-side model: serial input lanes and retimed data from the core
`timescale 1ns/1ps
module rcpc_far_model (
    input logic [3:0] lane_bits,
    input logic rt_bit,
    output logic [3:0] serial_in_p,
    output logic [3:0] serial_in_n,
    output logic retimed_p,
    output logic retimed_n
);
    // Inverting legs always complement, never left floating
    assign serial_in_p = lane_bits;
    assign serial_in_n = ~lane_bits;
    assign retimed_p = rt_bit;
    assign retimed_n = ~rt_bit;
endmodule // rcpc_far_model

/* verif/rcpc_top_sva.sv */
// Concurrent checks on the output path control pins and bus
`timescale 1ns/1ps
`include "rcpc_defs.vh"
module rcpc_top_sva (
    input logic pclk,
    input logic presetn,
    input logic penable,
    input logic pready,
    input logic pins_connected,
    input logic unlock_passthrough_en,
    input logic forced_passthrough,
    input logic output_silence_n,
    input logic loop_bw_boost_n,
    input logic [1:0] input_choice,
    input logic signal_present,
    input logic [11:0] freq_err_ppm,
    input logic [2:0] locked_rate,
    input logic [3:0] serial_in_p,
    input logic retimed_p,
    input logic serial_out_p,
    input logic serial_out_n,
    input logic lock_indicator_n,
    input logic sd_rate_flag,
    input logic loop_bw_high
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Windows of five cover the two sync stages plus output flops
    a_apb_wait: assert property ($rose(penable) |-> !pready ##1 pready)
        else $error("late pready");
    a_lock_gain: assert property (
        (signal_present && freq_err_ppm <= `RCPC_LOCK_PPM)[*5] |-> lock_indicator_n)
        else $error("no lock");
    a_lock_loss: assert property (
        (!signal_present || freq_err_ppm > `RCPC_UNLOCK_PPM)[*5] |-> !lock_indicator_n)
        else $error("lock kept");
    a_rate_flag: assert property (
        (lock_indicator_n && $stable(locked_rate))[*5]
        |-> sd_rate_flag == (locked_rate != `RCPC_RATE_HD))
        else $error("bad rate flag");
    a_loop_bw: assert property (
        (pins_connected && $stable(loop_bw_boost_n))[*5] |-> loop_bw_high == !loop_bw_boost_n)
        else $error("bad bandwidth");
    a_mute_out: assert property (
        (pins_connected && !output_silence_n)[*5] |-> !serial_out_p && !serial_out_n)
        else $error("not muted");
    a_forced_sel: assert property (
        (pins_connected && forced_passthrough && output_silence_n && $stable(input_choice)
        && $stable(serial_in_p))[*5] |-> serial_out_p == serial_in_p[input_choice])
        else $error("bad bypass");
    a_retimed_out: assert property (
        (pins_connected && !forced_passthrough && !unlock_passthrough_en && output_silence_n
        && $stable(retimed_p))[*5] |-> serial_out_p == retimed_p)
        else $error("bad retimed");
    cover property ($rose(lock_indicator_n));
    cover property ($fell(lock_indicator_n));
    cover property (!serial_out_p && !serial_out_n);
endmodule // rcpc_top_sva
////////////////////////////////////////////////////////////////////////////////
bind rcpc_top rcpc_top_sva u_sva (.pclk(pclk), .presetn(presetn), .penable(penable),
    .pready(pready), .pins_connected(pins_connected),
    .unlock_passthrough_en(unlock_passthrough_en), .forced_passthrough(forced_passthrough),
    .output_silence_n(output_silence_n), .loop_bw_boost_n(loop_bw_boost_n),
    .input_choice(input_choice), .signal_present(signal_present),
    .freq_err_ppm(freq_err_ppm), .locked_rate(locked_rate), .serial_in_p(serial_in_p),
    .retimed_p(retimed_p), .serial_out_p(serial_out_p), .serial_out_n(serial_out_n),
    .lock_indicator_n(lock_indicator_n), .sd_rate_flag(sd_rate_flag),
    .loop_bw_high(loop_bw_high));

/* verif/rcpc_top_tb.sv */
// Self-checking bench for the reclocker output path control
`timescale 1ns/1ps
`include "rcpc_defs.vh"
module rcpc_top_tb;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, pc, rt, sig, perr;
    logic [11:0] paddr, err;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] pv;
    logic [3:0] lane, sip, sin;
    logic [2:0] rate;
    logic rtp, rtn, sop, son, lkn, sdf, bwh, fll, rfp, rfn;
    int checks = 0;
    int num_errors = 0;
    always #5 pclk = ~pclk;
    rcpc_far_model far (.lane_bits(lane), .rt_bit(rt), .serial_in_p(sip), .serial_in_n(sin),
        .retimed_p(rtp), .retimed_n(rtn));
    rcpc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pins_connected(pc), .unlock_passthrough_en(pv[0]),
        .forced_passthrough(pv[1]), .output_silence_n(pv[2]), .loop_bw_boost_n(pv[3]),
        .input_choice(pv[5:4]), .signal_present(sig), .freq_err_ppm(err),
        .locked_rate(rate), .serial_in_p(sip), .serial_in_n(sin), .retimed_p(rtp),
        .retimed_n(rtn), .retime_feed_p(rfp), .retime_feed_n(rfn), .serial_out_p(sop),
        .serial_out_n(son), .lock_indicator_n(lkn), .sd_rate_flag(sdf),
        .loop_bw_high(bwh), .fll_enable(fll));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pins need two sync edges plus output flops
    task automatic wt;
        repeat (6) @(posedge pclk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        results;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pc = 1'b0;
        pv = 6'h32;
        lane = 4'h1;
        rt = 1'b0;
        sig = 1'b0;
        err = 12'hFFF;
        rate = 3'h5;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wt;
        chk({sop, son, bwh, lkn, rfp, rfn}, 6'h22);
        apb(1'b0, `RCPC_OFF_CTRL, 32'h0);
        chk(rd, 32'h1A);
        apb(1'b0, 12'h010, 32'h0);
        chk({perr, rd[30:0]}, 32'h80000000);
        apb(1'b1, `RCPC_OFF_INT_MASK, 32'h3);
        @(posedge pclk);
        pc <= 1'b1;
        pv <= 6'h0D;
        wt;
        chk({sop, son}, 2'h2);
        @(posedge pclk);
        pv <= 6'h0C;
        wt;
        chk({sop, son, bwh}, 3'h2);
        for (int ch = 0; ch < 4; ch++)
        begin
            @(posedge pclk);
            pv <= {ch[1:0], 4'hE};
            lane <= 4'h1 << ch;
            wt;
            chk({sop, son, rfp, rfn}, 4'hA);
        end
        @(posedge pclk);
        pv <= 6'h3A;
        wt;
        chk({sop, son}, 2'h0);
        @(posedge pclk);
        pv <= 6'h05;
        lane <= 4'h1;
        wt;
        chk({sop, son, bwh}, 3'h5);
        @(posedge pclk);
        pv <= 6'h0D;
        sig <= 1'b1;
        err <= 12'd1500;
        rt <= 1'b1;
        lane <= 4'h0;
        wt;
        chk({lkn, sdf, fll, irq, sop, bwh}, 6'h26);
        apb(1'b1, `RCPC_OFF_INT_STATUS, 32'h1);
        wt;
        chk(irq, 32'h0);
        @(posedge pclk);
        rate <= 3'h2;
        wt;
        chk({sdf, irq}, 2'h2);
        apb(1'b0, `RCPC_OFF_INT_STATUS, 32'h0);
        chk(rd, 32'h4);
        @(posedge pclk);
        err <= 12'd2500;
        wt;
        chk(lkn, 32'h1);
        @(posedge pclk);
        err <= 12'd3500;
        wt;
        chk({lkn, sdf, fll, irq}, 4'h7);
        apb(1'b0, `RCPC_OFF_STATUS, 32'h0);
        chk(rd[3:0], 4'h6);
        // Register override mutes although the silence pin says run
        apb(1'b1, `RCPC_OFF_CTRL, 32'h13);
        wt;
        chk({sop, son}, 2'h0);
        apb(1'b0, `RCPC_OFF_STATUS, 32'h0);
        chk(rd[3:0], 4'hE);
        apb(1'b0, `RCPC_OFF_CTRL, 32'h0);
        chk(rd, 32'h13);
        results;
    end
endmodule // rcpc_top_tb
